//--- hdl/mcc_pkg.sv
// constants and carrier types for the monitor conversion control block
// assumes register accesses arrive already decoded from the serial bus
package mcc_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [7:0] ADDR_CONV_RATE = 8'h07;
  localparam logic [7:0] ADDR_SKIP_MASK = 8'h08;
  localparam logic [7:0] ADDR_ONE_SHOT = 8'h09;
  localparam logic [7:0] ADDR_BUSY = 8'h0C;
  localparam int RATE_CONT_BIT = 0;
  localparam int ONE_SHOT_BIT = 0;
  localparam int BUSY_CONV_BIT = 0;
  localparam int BUSY_NOT_READY_BIT = 1;
  localparam logic CONV_RATE_RESET = 1'h0;
  localparam logic [7:0] SKIP_MASK_RESET = 8'h00;
  localparam logic [7:0] WRITABLE_ALL = 8'hFF;
  localparam logic [7:0] WRITABLE_MODE2 = 8'h8F;
  localparam logic [7:0] WRITABLE_MODE3 = 8'hBF;
  localparam int READING_BITS = 12;
  localparam int POWERUP_NS = 2000;
  localparam int LOWPOWER_GAP_NS = 10000;
  localparam int POWERUP_CYCLES = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYCLES = (LOWPOWER_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_SE7_TEMP,
    MODE_SE8,
    MODE_PAIRS_TEMP,
    MODE_MIXED_TEMP
  } mcc_mode_t;

  typedef enum logic [1:0] {
    KIND_SINGLE,
    KIND_PSEUDO_DIFF,
    KIND_TEMPERATURE,
    KIND_NONE
  } mcc_kind_t;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcc_reg_req_t;

  typedef struct packed {
    mcc_kind_t kind;
    logic [2:0] posIn;
    logic [2:0] negIn;
  } mcc_conv_req_t;

  typedef struct packed {
    logic [2:0] slot;
    logic [READING_BITS-1:0] value;
  } mcc_reading_t;
endpackage

//--- hdl/mcc_interval_timer.sv
// down-counter that paces power-up and the low-power gap between rounds
// assumes load is a one-cycle pulse; counts from RESET_COUNT after reset
`timescale 1ns/10ps
`default_nettype none
module mcc_interval_timer #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_COUNT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  // status
  output logic expired
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  assign count_d = load ? loadValue : (expired ? count_q : count_q - {{(WIDTH-1){1'b0}}, 1'b1});
  assign expired = (count_q == '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= RESET_COUNT;
    end else begin
      count_q <= count_d;
    end
  end
endmodule
`default_nettype wire

//--- hdl/mcc_conv_control.sv
// conversion sequencer with rate, skip-mask and one-shot registers
// assumes decoded register accesses and an external converter with a done strobe
`timescale 1ns/10ps
`default_nettype none
module mcc_conv_control #(
  parameter int TIMER_WIDTH = 16,
  parameter int POWERUP_CYCLES = mcc_pkg::POWERUP_CYCLES,
  parameter int GAP_CYCLES = mcc_pkg::GAP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access
  input wire mcc_pkg::mcc_reg_req_t regReq,
  output logic [7:0] regRdData_q,
  // configuration from neighbouring registers
  input wire logic startBit,
  input wire logic [1:0] modeSel,
  input wire logic deepShutdownEn,
  // converter
  output logic convReq_q,
  output mcc_pkg::mcc_conv_req_t convInfo_q,
  input wire logic convDone,
  input wire logic [mcc_pkg::READING_BITS-1:0] convData,
  // results
  output logic readingWr_q,
  output mcc_pkg::mcc_reading_t reading_q,
  output logic clearAll_q,
  output logic [7:0] errorEnable_q,
  // status
  output logic deepShutdown_q,
  output logic busyConv_q,
  output logic notReady_q
);
  if (POWERUP_CYCLES < 1 || GAP_CYCLES < 1 ||
      POWERUP_CYCLES >= (1 << TIMER_WIDTH) || GAP_CYCLES >= (1 << TIMER_WIDTH)) begin : g_chk
    $error("timer counts do not fit TIMER_WIDTH");
  end

  typedef enum logic [2:0] {ST_POWERUP, ST_IDLE, ST_SELECT, ST_WAIT, ST_GAP} mcc_state_t;

  function automatic mcc_pkg::mcc_conv_req_t pairOf(input logic [1:0] p);
    mcc_pkg::mcc_conv_req_t r;
    r.kind = mcc_pkg::KIND_PSEUDO_DIFF;
    case (p)
      2'h0: begin r.posIn = 3'h0; r.negIn = 3'h1; end
      2'h1: begin r.posIn = 3'h3; r.negIn = 3'h2; end
      2'h2: begin r.posIn = 3'h4; r.negIn = 3'h5; end
      default: begin r.posIn = 3'h7; r.negIn = 3'h6; end
    endcase
    return r;
  endfunction

  // what each reading slot converts in each input mode
  function automatic mcc_pkg::mcc_conv_req_t slotMap(input mcc_pkg::mcc_mode_t m,
                                                      input logic [2:0] s);
    mcc_pkg::mcc_conv_req_t r;
    r.kind = mcc_pkg::KIND_SINGLE;
    r.posIn = s;
    r.negIn = 3'h0;
    case (m)
      mcc_pkg::MODE_SE7_TEMP: if (s == 3'h7) r.kind = mcc_pkg::KIND_TEMPERATURE;
      mcc_pkg::MODE_SE8: r.kind = mcc_pkg::KIND_SINGLE;
      mcc_pkg::MODE_PAIRS_TEMP: begin
        if (s < 3'h4) r = pairOf(s[1:0]);
        else if (s == 3'h7) r.kind = mcc_pkg::KIND_TEMPERATURE;
        else r.kind = mcc_pkg::KIND_NONE;
      end
      default: begin
        if (s == 3'h4) r = pairOf(2'h2);
        else if (s == 3'h5) r = pairOf(2'h3);
        else if (s == 3'h6) r.kind = mcc_pkg::KIND_NONE;
        else if (s == 3'h7) r.kind = mcc_pkg::KIND_TEMPERATURE;
      end
    endcase
    return r;
  endfunction

  function automatic logic [7:0] writableMask(input mcc_pkg::mcc_mode_t m);
    case (m)
      mcc_pkg::MODE_PAIRS_TEMP: return mcc_pkg::WRITABLE_MODE2;
      mcc_pkg::MODE_MIXED_TEMP: return mcc_pkg::WRITABLE_MODE3;
      default: return mcc_pkg::WRITABLE_ALL;
    endcase
  endfunction

  mcc_state_t state_q;
  mcc_state_t state_d;
  logic [2:0] slotIdx_q;
  logic [2:0] slotIdx_d;
  logic oneShotRun_q;
  logic oneShotRun_d;
  logic rateCont_q;
  logic [7:0] skipMask_q;
  logic convReq_d;
  logic readWr_d;
  logic [mcc_pkg::READING_BITS-1:0] readVal_d;
  logic roundStep;
  logic gapLoad;
  logic timerExpired;
  logic [7:0] slotActive;
  logic [7:0] rdMux;
  mcc_pkg::mcc_mode_t mode;

  assign mode = mcc_pkg::mcc_mode_t'(modeSel);

  wire wrRate = regReq.wrEn && (regReq.addr == mcc_pkg::ADDR_CONV_RATE);
  wire wrSkip = regReq.wrEn && (regReq.addr == mcc_pkg::ADDR_SKIP_MASK);
  // the trigger is never stored: only the write itself starts a round
  wire oneShotHit = regReq.wrEn && (regReq.addr == mcc_pkg::ADDR_ONE_SHOT) &&
                    regReq.wdata[mcc_pkg::ONE_SHOT_BIT] && !startBit;
  wire lastSlot = (slotIdx_q == 3'h7);
  wire endRound = roundStep && lastSlot;
  wire [7:0] skipNext = regReq.wdata & writableMask(mode);

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      slotActive[i] = (slotMap(mode, 3'(i)).kind != mcc_pkg::KIND_NONE) &&
                      !skipMask_q[i];
    end
  end

  mcc_interval_timer #(
    .WIDTH(TIMER_WIDTH),
    .RESET_COUNT(TIMER_WIDTH'(POWERUP_CYCLES))
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(gapLoad),
    .loadValue(TIMER_WIDTH'(GAP_CYCLES)),
    .expired(timerExpired)
  );

  always_comb begin
    state_d = state_q;
    slotIdx_d = slotIdx_q;
    oneShotRun_d = oneShotRun_q;
    convReq_d = 1'b0;
    readWr_d = 1'b0;
    readVal_d = '0;
    roundStep = 1'b0;
    gapLoad = 1'b0;
    case (state_q)
      ST_POWERUP: if (timerExpired) state_d = ST_IDLE;
      ST_IDLE: begin
        if (oneShotHit) begin
          oneShotRun_d = 1'b1;
          slotIdx_d = 3'h0;
          state_d = ST_SELECT;
        end else if (startBit) begin
          slotIdx_d = 3'h0;
          state_d = ST_SELECT;
        end
      end
      ST_SELECT: begin
        if (!startBit && !oneShotRun_q) begin
          state_d = ST_IDLE;
        end else if (slotActive[slotIdx_q]) begin
          convReq_d = 1'b1;
          state_d = ST_WAIT;
        end else begin
          // skipped slot: no conversion, reading forced to zero
          readWr_d = 1'b1;
          roundStep = 1'b1;
        end
      end
      ST_WAIT: begin
        if (convDone) begin
          readWr_d = 1'b1;
          readVal_d = convData;
          roundStep = 1'b1;
        end
      end
      ST_GAP: begin
        if (!startBit) begin
          state_d = ST_IDLE;
        end else if (timerExpired) begin
          slotIdx_d = 3'h0;
          state_d = ST_SELECT;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (roundStep) begin
      slotIdx_d = slotIdx_q + 3'h1;
      if (!lastSlot) begin
        state_d = ST_SELECT;
      end else if (oneShotRun_q) begin
        oneShotRun_d = 1'b0;
        state_d = ST_IDLE;
      end else if (!startBit) begin
        state_d = ST_IDLE;
      end else if (rateCont_q) begin
        state_d = ST_SELECT;
      end else begin
        state_d = ST_GAP;
        gapLoad = 1'b1;
      end
    end
  end

  always_comb begin
    case (regReq.addr)
      mcc_pkg::ADDR_CONV_RATE: rdMux = {7'h00, rateCont_q};
      mcc_pkg::ADDR_SKIP_MASK: rdMux = skipMask_q;
      mcc_pkg::ADDR_BUSY: rdMux = {6'h00, notReady_q, busyConv_q};
      default: rdMux = 8'h00; // one-shot is write-only
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_POWERUP;
      slotIdx_q <= 3'h0;
      oneShotRun_q <= 1'b0;
      rateCont_q <= mcc_pkg::CONV_RATE_RESET;
      skipMask_q <= mcc_pkg::SKIP_MASK_RESET;
      regRdData_q <= 8'h00;
      convReq_q <= 1'b0;
      convInfo_q <= '0;
      readingWr_q <= 1'b0;
      reading_q <= '0;
      clearAll_q <= 1'b0;
      errorEnable_q <= 8'h00;
      deepShutdown_q <= 1'b0;
      busyConv_q <= 1'b0;
      notReady_q <= 1'b1;
    end else begin
      state_q <= state_d;
      slotIdx_q <= slotIdx_d;
      oneShotRun_q <= oneShotRun_d;
      if (wrRate) rateCont_q <= regReq.wdata[mcc_pkg::RATE_CONT_BIT];
      if (wrSkip) skipMask_q <= skipNext;
      if (regReq.rdEn) regRdData_q <= rdMux;
      convReq_q <= convReq_d;
      if (convReq_d) convInfo_q <= slotMap(mode, slotIdx_q);
      readingWr_q <= readWr_d;
      if (readWr_d) reading_q <= '{slot: slotIdx_q, value: readVal_d};
      clearAll_q <= wrSkip;
      errorEnable_q <= slotActive;
      deepShutdown_q <= deepShutdownEn && !startBit && (state_d == ST_IDLE);
      busyConv_q <= (state_d == ST_SELECT) || (state_d == ST_WAIT);
      notReady_q <= (state_d == ST_POWERUP);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_CONT_RESTART: assert property (endRound && rateCont_q && startBit && !oneShotRun_q
    |=> state_q == ST_SELECT && slotIdx_q == 3'h0) else $error("continuous round did not restart");
  AST_LOWPOWER_GAP: assert property (endRound && !rateCont_q && startBit && !oneShotRun_q
    |=> state_q == ST_GAP ##1 state_q != ST_SELECT) else $error("low-power gap skipped");
  AST_SKIP_CLEARS: assert property (wrSkip |=> clearAll_q && skipMask_q == $past(skipNext))
    else $error("skip-mask write did not clear readings");
  AST_SKIPPED_ZERO: assert property (readWr_d && !slotActive[slotIdx_q]
    |=> readingWr_q && reading_q.value == '0) else $error("skipped slot reading not zero");
  AST_NO_SKIPPED_CONV: assert property (convReq_q |-> $past(slotActive[slotIdx_q]))
    else $error("conversion issued for a skipped slot");
  AST_MODE1_ALL: assert property (modeSel == 2'h1 && skipMask_q == 8'h00 |=> errorEnable_q == 8'hFF)
    else $error("mode 1 slot missing");
  AST_MODE2_RESERVED: assert property (modeSel == 2'h2 |=> errorEnable_q[6:4] == 3'h0)
    else $error("mode 2 reserved slot active");
  AST_MODE3_RESERVED: assert property (modeSel == 2'h3 |=> !errorEnable_q[6])
    else $error("mode 3 reserved slot active");
  AST_ONESHOT_START: assert property (state_q == ST_IDLE && oneShotHit
    |=> oneShotRun_q && state_q == ST_SELECT && slotIdx_q == 3'h0) else $error("one-shot not started");
  AST_ONESHOT_END: assert property (endRound && oneShotRun_q |=> state_q == ST_IDLE && !oneShotRun_q)
    else $error("one-shot did not return to shutdown");
  AST_DEEP_SHUTDOWN: assert property (deepShutdownEn && !startBit && state_q == ST_IDLE && !oneShotHit
    |=> deepShutdown_q) else $error("deep shutdown not entered");
  AST_BUSY_READ: assert property (regReq.rdEn && regReq.addr == mcc_pkg::ADDR_BUSY
    |=> regRdData_q == {6'h00, $past(notReady_q), $past(busyConv_q)}) else $error("busy read wrong");
  AST_ONESHOT_READS_ZERO: assert property (regReq.rdEn && regReq.addr == mcc_pkg::ADDR_ONE_SHOT
    |=> regRdData_q == 8'h00) else $error("one-shot register holds state");
endmodule
`default_nettype wire

//--- test/mcc_conv_model.sv
// behavioural converter that answers each request after a chosen latency
// assumes one request at a time, since the sequencer waits for each answer
`timescale 1ns/10ps
`default_nettype none
module mcc_conv_model (
  // clock
  input wire logic clk,
  // request
  input wire logic convReq,
  input wire mcc_pkg::mcc_conv_req_t info,
  input wire logic [1:0] lat,
  // answer
  output logic convDone,
  output logic [mcc_pkg::READING_BITS-1:0] convData
);
  initial begin
    convDone = 1'b0;
    convData = 12'hFFF;
    forever begin
      @(posedge clk);
      if (convReq === 1'b1) begin
        repeat (lat) @(posedge clk);
        #1;
        convDone = 1'b1;
        convData = (info.kind == mcc_pkg::KIND_TEMPERATURE) ? 12'h7E5 :
          {1'b0, info.kind, info.posIn, info.negIn, 3'h5};
        @(posedge clk);
        #1;
        convDone = 1'b0;
        // stale data is inverted so a late sample never looks valid
        convData = ~convData;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/monitor_conversion_control_tb.sv
// self-checking bench for the conversion sequencer
// assumes the converter model answers on convDone; bench acts as the host
`timescale 1ns/10ps
`default_nettype none
module monitor_conversion_control_tb;
  localparam int PWR = 4;
  localparam int GAP = 5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  mcc_pkg::mcc_reg_req_t regReq = '0;
  logic startBit = 1'b0;
  logic [1:0] modeSel = 2'h0;
  logic deepShutdownEn = 1'b0;
  logic [1:0] lat = 2'h1;
  logic convDone, convReq_q, readingWr_q, clearAll_q, deepShutdown_q, busyConv_q, notReady_q;
  logic [11:0] convData;
  logic [7:0] regRdData_q, errorEnable_q;
  mcc_pkg::mcc_conv_req_t convInfo_q;
  mcc_pkg::mcc_reading_t reading_q;
  int num_errors = 0;
  int n_tests = 0;
  int seed = 50527;
  int nReq = 0;
  logic rdSeen = 1'b0;
  logic drain = 1'b0;
  logic [15:0] expQ[$];
  always #12.5 clk = ~clk;
  mcc_conv_control #(.POWERUP_CYCLES(PWR), .GAP_CYCLES(GAP)) i_mcc_conv_control (
    .clk(clk), .rst_n(rst_n), .regReq(regReq), .regRdData_q(regRdData_q),
    .startBit(startBit), .modeSel(modeSel), .deepShutdownEn(deepShutdownEn),
    .convReq_q(convReq_q), .convInfo_q(convInfo_q), .convDone(convDone), .convData(convData),
    .readingWr_q(readingWr_q), .reading_q(reading_q), .clearAll_q(clearAll_q),
    .errorEnable_q(errorEnable_q), .deepShutdown_q(deepShutdown_q),
    .busyConv_q(busyConv_q), .notReady_q(notReady_q));
  mcc_conv_model i_mcc_conv_model (.clk(clk), .convReq(convReq_q), .info(convInfo_q),
    .lat(lat), .convDone(convDone), .convData(convData));
  task automatic summarize;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // accesses stay back to back until tick lowers the strobes
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    regReq = '{w, ~w, a, d};
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back({8'h00, e});
    acc(1'b0, a, 8'h00);
  endtask
  task automatic tick(input int n);
    regReq = '0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic waitQ(input int k);
    for (int i = 0; i < 600 && expQ.size() > k; i++) tick(1);
  endtask
  function automatic logic [15:0] expRd(input logic [1:0] m, input logic [7:0] en, input int s);
    logic [11:0] v;
    logic [2:0] p;
    logic pd;
    pd = (m == 2'h2 && s < 4) || (m == 2'h3 && (s == 4 || s == 5));
    p = (m == 2'h2) ? {s[1], s[0], s[0]} : (m == 2'h3 && s == 5) ? 3'h7 : 3'(s);
    // pairs always use the neighbour of the positive input as the negative one
    v = (s == 7 && m != 2'h1) ? 12'h7E5 :
      {1'b0, pd ? 2'h1 : 2'h0, p, pd ? p ^ 3'h1 : 3'h0, 3'h5};
    return {1'b0, 3'(s), en[s] ? v : 12'h000};
  endfunction
  always @(posedge clk) begin
    if (rdSeen || (readingWr_q && !drain)) begin
      if (expQ.size() == 0) begin
        chk(16'hFFFF, 16'h0000);
      end else begin
        chk(rdSeen ? {8'h00, regRdData_q} : {1'b0, reading_q}, expQ.pop_front());
      end
    end
    rdSeen = regReq.rdEn;
    if (convReq_q) nReq++;
  end
  task automatic round(input logic [1:0] m);
    logic [7:0] mask, en, wm;
    logic dse;
    mask = 8'($random(seed));
    dse = 1'($random(seed));
    wm = (m == 2'h2) ? mcc_pkg::WRITABLE_MODE2 :
      (m == 2'h3) ? mcc_pkg::WRITABLE_MODE3 : mcc_pkg::WRITABLE_ALL;
    en = ~mask & wm;
    modeSel = m;
    deepShutdownEn = dse;
    lat = mask[2:1];
    acc(1'b1, mcc_pkg::ADDR_SKIP_MASK, mask);
    chk(16'(clearAll_q), 16'h1);
    rd(mcc_pkg::ADDR_SKIP_MASK, ~en & wm);
    rd(mcc_pkg::ADDR_ONE_SHOT, 8'h00);
    tick(1);
    chk(16'(errorEnable_q), 16'(en));
    chk(16'(deepShutdown_q), 16'(dse));
    for (int s = 0; s < 8; s++) expQ.push_back(expRd(m, en, s));
    nReq = 0;
    acc(1'b1, mcc_pkg::ADDR_ONE_SHOT, 8'h01);
    waitQ(0);
    tick(20);
    chk(16'(expQ.size()), 16'h0);
    chk(16'(nReq), 16'($countones(en)));
    chk({busyConv_q, deepShutdown_q}, {1'b0, dse});
    $display("test one-shot mode %0d done", m);
  endtask
  task automatic run(input logic r, output int n);
    modeSel = {1'b0, r};
    deepShutdownEn = r;
    lat = 2'h0;
    acc(1'b1, mcc_pkg::ADDR_CONV_RATE, {7'h7F, r});
    acc(1'b1, mcc_pkg::ADDR_SKIP_MASK, 8'h00);
    rd(mcc_pkg::ADDR_CONV_RATE, {7'h00, r});
    tick(1);
    for (int s = 0; s < 16; s++) expQ.push_back(expRd({1'b0, r}, 8'hFF, s % 8));
    startBit = 1'b1;
    tick(3);
    chk({busyConv_q, deepShutdown_q}, {1'b1, 1'b0});
    waitQ(8);
    n = 0;
    while (expQ.size() > 7 && n < 600) begin
      tick(1);
      n++;
    end
    waitQ(0);
    // a second round that never comes must not pass as a long gap
    chk(16'(expQ.size()), 16'h0);
    startBit = 1'b0;
    drain = 1'b1;
    tick(80);
    drain = 1'b0;
    chk(16'(deepShutdown_q), 16'(r));
    $display("test rate %0d done", r);
  endtask
  initial begin
    int nc, nl;
    tick(12);
    rst_n = 1'b1;
    chk(16'(notReady_q), 16'h1);
    rd(mcc_pkg::ADDR_BUSY, 8'h02);
    rd(mcc_pkg::ADDR_CONV_RATE, 8'h00);
    rd(mcc_pkg::ADDR_SKIP_MASK, mcc_pkg::SKIP_MASK_RESET);
    rd(8'h3F, 8'h00);
    tick(PWR + 4);
    chk(16'(notReady_q), 16'h0);
    rd(mcc_pkg::ADDR_BUSY, 8'h00);
    for (int m = 0; m < 4; m++) begin
      modeSel = 2'(m);
      acc(1'b1, mcc_pkg::ADDR_SKIP_MASK, 8'hFF);
      rd(mcc_pkg::ADDR_SKIP_MASK, (m == 2) ? 8'h8F : (m == 3) ? 8'hBF : 8'hFF);
    end
    tick(2);
    $display("test reset and masks done");
    for (int k = 0; k < 4; k++) round(2'(k));
    run(1'b1, nc);
    run(1'b0, nl);
    // low-power rounds must leave at least the gap between them
    chk(16'(nl >= nc + GAP), 16'h1);
    // reset in the low-power gap after a round must clear busy, convReq and readingWr and raise notReady
    startBit = 1'b1;
    drain = 1'b1;
    tick(30);
    rst_n = 1'b0;
    tick(3);
    startBit = 1'b0;
    drain = 1'b0;
    chk({busyConv_q, notReady_q, convReq_q, readingWr_q}, 4'h4);
    rst_n = 1'b1;
    rd(mcc_pkg::ADDR_BUSY, 8'h02);
    tick(PWR + 4);
    rd(mcc_pkg::ADDR_BUSY, 8'h00);
    tick(2);
    $display("test mid-run reset done");
    summarize();
  end
  initial begin
    #(25 * 30000);
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
